//--- qus_top.sv
// Four-channel serial and modem pin block with FIFO status snapshot port.
// Assumes host logic on REF_CLK_I; pins are asynchronous and synchronised.
// Summary of operation
// - Status select low drives the status snapshot onto the data bus.
// - Snapshot bits 0..3 are inverted transmit-ready pins, channel A lowest.
// - Snapshot bits 4..7 are raw receive-ready pins, channel A in bit 4.
// - Snapshot read ignores register address lines entirely.
// - Infrared select clear: plain serial transmit, high in reset and idle.
// - Infrared select set: infrared coding on transmit and receive, idle low.
// - Dedicated infrared transmit pin always carries infrared code, idle low.
// - Clear-to-send gates transmission when automatic mode is enabled.
// - Request-to-send and terminal-ready outputs are active low, host driven.
// - Clear, set-ready and carrier inputs are active low, readable.
// - Set-ready and carrier inputs are status only, no effect on data.
// - Each channel drives active-low transmit-ready and receive-ready pins.
`timescale 1ns/1ns
module qus_top #(
  parameter logic [15:0] BAUD_DIV = qus_pkg::BAUD_DIV_DEF
) (
  input  wire logic            REF_CLK_I,          // 100 MHz clock
  input  wire logic            RSTN_I,             // Async reset, active low
  input  wire logic            FIFO_STATUS_SELECT_N_I, // Snapshot select
  output logic [7:0]           DATA_O,             // Host data bus out
  output logic                 DATA_OE_O,          // Data bus drive enable
  input  wire logic [3:0][7:0] TX_DATA_I,          // Words to send
  input  wire logic [3:0]      TX_VALID_I,         // Word offered
  output logic [3:0]           TX_READY_O,         // Word taken
  output logic [3:0][7:0]      RX_DATA_O,          // Received words
  output logic [3:0]           RX_VALID_O,         // Received word held
  input  wire logic [3:0]      RX_READY_I,         // Host takes the word
  input  wire logic [3:0]      INFRARED_SELECT_I,  // Infrared mode bit
  input  wire logic [3:0]      REQUEST_TO_SEND_BIT_I, // Assert RTS
  input  wire logic [3:0]      DATA_TERMINAL_READY_BIT_I, // Assert DTR
  input  wire logic [3:0]      AUTO_RTS_ENABLE_I,  // Automatic RTS
  input  wire logic [3:0]      AUTO_CTS_ENABLE_I,  // Automatic CTS
  output logic [3:0]           TX_O,               // Serial transmit pins
  output logic [3:0]           INFRARED_TX_O,      // Infrared transmit pins
  input  wire logic [3:0]      RX_I,               // Serial receive pins
  output logic [3:0]           RTS_N_O,            // Request to send
  output logic [3:0]           DTR_N_O,            // Terminal ready
  input  wire logic [3:0]      CTS_N_I,            // Clear to send
  input  wire logic [3:0]      DSR_N_I,            // Data set ready
  input  wire logic [3:0]      CD_N_I,             // Carrier detect
  output logic [3:0]           CTS_STATUS_O,       // CTS asserted
  output logic [3:0]           DSR_STATUS_O,       // DSR asserted
  output logic [3:0]           CD_STATUS_O,        // Carrier asserted
  output logic [3:0]           TRANSMIT_READY_N_O, // Transmit buffer room
  output logic [3:0]           RECEIVE_READY_N_O   // Receive data held
);
  typedef struct packed {
    qus_pkg::qus_chan_t [3:0] ch;
    logic [15:0]              div;
    logic                     tick;
    logic                     fsel_s1;
    logic                     fsel_s2;
    logic [3:0]               rx_s3;
    logic [7:0]               data;
    logic                     data_oe;
  } qus_st_t;

  localparam qus_st_t ST_RST = '{ch: {qus_pkg::NCH{qus_pkg::CH_RST}},
    div: 16'h0000, tick: 1'b0, fsel_s1: 1'b1, fsel_s2: 1'b1, rx_s3: 4'hf,
    data: qus_pkg::DATA_RST, data_oe: 1'b0};

  qus_st_t          q;
  qus_st_t          d;
  logic [3:0]       txb_valid;
  logic [3:0][7:0]  txb_data;
  logic [3:0]       txb_pop;
  logic [3:0]       rxb_ready;

  genvar g;
  generate
    for (g = 0; g < qus_pkg::NCH; g++) begin : g_ch
      qus_buf2 #(
        .WIDTH (8)
      ) u_txb (
        .clk_i       (REF_CLK_I),
        .rst_n_i     (RSTN_I),
        .in_valid_i  (TX_VALID_I[g]),
        .in_data_i   (TX_DATA_I[g]),
        .in_ready_o  (TX_READY_O[g]),
        .out_valid_o (txb_valid[g]),
        .out_data_o  (txb_data[g]),
        .out_ready_i (txb_pop[g])
      );
      qus_buf2 #(
        .WIDTH (8)
      ) u_rxb (
        .clk_i       (REF_CLK_I),
        .rst_n_i     (RSTN_I),
        .in_valid_i  (q.ch[g].rx_push),
        .in_data_i   (q.ch[g].rx_sh),
        .in_ready_o  (rxb_ready[g]),
        .out_valid_o (RX_VALID_O[g]),
        .out_data_o  (RX_DATA_O[g]),
        .out_ready_i (RX_READY_I[g])
      );
      assign TX_O[g]               = q.ch[g].tx_pin;
      assign INFRARED_TX_O[g]      = q.ch[g].irtx_pin;
      assign RTS_N_O[g]            = q.ch[g].rts_n;
      assign DTR_N_O[g]            = q.ch[g].dtr_n;
      assign CTS_STATUS_O[g]       = ~q.ch[g].cts_s2;
      assign DSR_STATUS_O[g]       = ~q.ch[g].dsr_s2;
      assign CD_STATUS_O[g]        = ~q.ch[g].cd_s2;
      assign TRANSMIT_READY_N_O[g] = q.ch[g].transmit_ready_n_n;
      assign RECEIVE_READY_N_O[g]  = q.ch[g].receive_ready_n_n;
    end
  endgenerate

  assign DATA_O    = q.data;
  assign DATA_OE_O = q.data_oe;

  always_comb begin
    logic line;
    logic ser;
    logic [3:0] txr_n;
    logic [3:0] rxr_n;
    line  = 1'b1;
    ser   = 1'b1;
    txr_n = '0;
    rxr_n = '0;
    d = q;
    txb_pop = '0;
    // Shared 16x bit-rate tick
    d.tick = 1'b0;
    if (q.div >= BAUD_DIV - qus_pkg::DIV_ONE) begin
      d.div  = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + qus_pkg::DIV_ONE;
    end
    d.fsel_s1 = FIFO_STATUS_SELECT_N_I;
    d.fsel_s2 = q.fsel_s1;
    for (int i = 0; i < qus_pkg::NCH; i++) begin
      d.ch[i].rx_s1  = RX_I[i];
      d.ch[i].rx_s2  = q.ch[i].rx_s1;
      d.ch[i].cts_s1 = CTS_N_I[i];
      d.ch[i].cts_s2 = q.ch[i].cts_s1;
      d.ch[i].dsr_s1 = DSR_N_I[i];
      d.ch[i].dsr_s2 = q.ch[i].dsr_s1;
      d.ch[i].cd_s1  = CD_N_I[i];
      d.ch[i].cd_s2  = q.ch[i].cd_s1;
      d.ch[i].rx_push = 1'b0;
      // Infrared receive: a high pulse is stretched to one bit of zero.
      // Only a rising edge starts a pulse, so a line left high by plain
      // mode is not taken for a start bit when infrared is switched on.
      d.rx_s3[i] = q.ch[i].rx_s2;
      if (!INFRARED_SELECT_I[i]) begin
        d.ch[i].ir_hold = 4'h0;
      end else if (q.ch[i].rx_s2
                   && (!q.rx_s3[i] || q.ch[i].ir_hold != 4'h0)) begin
        d.ch[i].ir_hold = qus_pkg::IR_HOLD;
      end else if (q.tick && q.ch[i].ir_hold != 4'h0) begin
        d.ch[i].ir_hold = q.ch[i].ir_hold - 4'h1;
      end
      line = INFRARED_SELECT_I[i] ? (q.ch[i].ir_hold == 4'h0)
                                  : q.ch[i].rx_s2;
      if (q.tick) begin
        if (!q.ch[i].rx_busy) begin
          if (!line) begin
            d.ch[i].rx_busy = 1'b1;
            d.ch[i].rx_bit  = 4'h0;
            d.ch[i].rx_sub  = 4'h0;
          end
        end else if (q.ch[i].rx_bit == 4'h0) begin
          d.ch[i].rx_sub = q.ch[i].rx_sub + 4'h1;
          if (q.ch[i].rx_sub == qus_pkg::SUB_HALF) begin
            // A start that is gone at mid-bit was noise
            d.ch[i].rx_busy = ~line;
            d.ch[i].rx_bit  = qus_pkg::BIT_ONE;
            d.ch[i].rx_sub  = 4'h0;
          end
        end else begin
          d.ch[i].rx_sub = q.ch[i].rx_sub + 4'h1;
          if (q.ch[i].rx_sub == qus_pkg::SUB_LAST) begin
            d.ch[i].rx_sub = 4'h0;
            d.ch[i].rx_bit = q.ch[i].rx_bit + 4'h1;
            if (q.ch[i].rx_bit == qus_pkg::BIT_LAST) begin
              // Framing error drops the word; a full buffer overruns
              d.ch[i].rx_busy = 1'b0;
              d.ch[i].rx_push = line;
            end else begin
              d.ch[i].rx_sh = {line, q.ch[i].rx_sh[7:1]};
            end
          end
        end
      end
      // Transmitter; the buffer is drained only on a tick
      if (q.tick) begin
        if (!q.ch[i].tx_busy) begin
          if (txb_valid[i] && (!AUTO_CTS_ENABLE_I[i]
                               || !q.ch[i].cts_s2)) begin
            txb_pop[i]      = 1'b1;
            d.ch[i].tx_sh   = {1'b1, txb_data[i], 1'b0};
            d.ch[i].tx_busy = 1'b1;
            d.ch[i].tx_bit  = 4'h0;
            d.ch[i].tx_sub  = 4'h0;
          end
        end else begin
          d.ch[i].tx_sub = q.ch[i].tx_sub + 4'h1;
          if (q.ch[i].tx_sub == qus_pkg::SUB_LAST) begin
            d.ch[i].tx_sh  = {1'b1, q.ch[i].tx_sh[9:1]};
            d.ch[i].tx_bit = q.ch[i].tx_bit + 4'h1;
            if (q.ch[i].tx_bit == qus_pkg::BIT_LAST) begin
              d.ch[i].tx_busy = 1'b0;
            end
          end
        end
      end
      ser = ~q.ch[i].tx_busy | q.ch[i].tx_sh[0];
      d.ch[i].irtx_pin = ~ser
                         && (q.ch[i].tx_sub < qus_pkg::IR_PULSE);
      d.ch[i].tx_pin = INFRARED_SELECT_I[i] ? d.ch[i].irtx_pin
                                            : ser;
      // Automatic RTS drops the request while the receive buffer is full
      d.ch[i].rts_n = ~(REQUEST_TO_SEND_BIT_I[i]
                        && (!AUTO_RTS_ENABLE_I[i] || rxb_ready[i]));
      d.ch[i].dtr_n   = ~DATA_TERMINAL_READY_BIT_I[i];
      d.ch[i].transmit_ready_n_n = ~TX_READY_O[i];
      d.ch[i].receive_ready_n_n = ~RX_VALID_O[i];
      txr_n[i] = q.ch[i].transmit_ready_n_n;
      rxr_n[i] = q.ch[i].receive_ready_n_n;
    end
    // No address is decoded: the select alone steers the bus
    d.data    = {rxr_n, ~txr_n};
    d.data_oe = ~q.fsel_s2;
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end
endmodule

//--- qus_buf2.sv
// Shared constants of the quad serial pin block, and the two-entry buffer
// that each channel uses on its transmit and its receive path.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
package qus_pkg;
  localparam int          NCH          = 4;
  localparam logic [15:0] BAUD_DIV_DEF = 16'h0036;
  localparam logic [15:0] DIV_ONE      = 16'h0001;
  localparam logic [3:0]  SUB_LAST     = 4'hf;
  localparam logic [3:0]  SUB_HALF     = 4'h7;
  localparam logic [3:0]  IR_PULSE     = 4'h3;
  localparam logic [3:0]  IR_HOLD      = 4'hf;
  localparam logic [3:0]  BIT_ONE      = 4'h1;
  localparam logic [3:0]  BIT_LAST     = 4'h9;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [1:0]  BUF_DEPTH    = 2'h2;

  typedef struct packed {
    logic       tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_sub;
    logic       tx_pin;
    logic       irtx_pin;
    logic       rx_s1;
    logic       rx_s2;
    logic [3:0] ir_hold;
    logic       rx_busy;
    logic [3:0] rx_bit;
    logic [3:0] rx_sub;
    logic [7:0] rx_sh;
    logic       rx_push;
    logic       cts_s1;
    logic       cts_s2;
    logic       dsr_s1;
    logic       dsr_s2;
    logic       cd_s1;
    logic       cd_s2;
    logic       rts_n;
    logic       dtr_n;
    logic       transmit_ready_n_n;
    logic       receive_ready_n_n;
  } qus_chan_t;

  localparam qus_chan_t CH_RST = '{tx_busy: 1'b0, tx_sh: 10'h3ff,
    tx_bit: 4'h0, tx_sub: 4'h0, tx_pin: 1'b1, irtx_pin: 1'b0,
    rx_s1: 1'b1, rx_s2: 1'b1, ir_hold: 4'h0, rx_busy: 1'b0,
    rx_bit: 4'h0, rx_sub: 4'h0, rx_sh: 8'h00, rx_push: 1'b0,
    cts_s1: 1'b1, cts_s2: 1'b1, dsr_s1: 1'b1, dsr_s2: 1'b1,
    cd_s1: 1'b1, cd_s2: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
    transmit_ready_n_n: 1'b1, receive_ready_n_n: 1'b1};
endpackage

module qus_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,       // Clock
  input  wire logic             rst_n_i,     // Async reset, active low
  input  wire logic             in_valid_i,  // Writer offers a word
  input  wire logic [WIDTH-1:0] in_data_i,   // Word offered
  output logic                  in_ready_o,  // Room for a word
  output logic                  out_valid_o, // A word is held
  output logic      [WIDTH-1:0] out_data_o,  // Oldest word
  input  wire logic             out_ready_i  // Reader takes the word
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0]            cnt;
    logic                  rdy;
    logic                  vld;
  } qus_buf_st_t;

  // Empty buffer has room, so ready rests high through reset
  localparam qus_buf_st_t BUF_RST = '{mem: '0, cnt: 2'h0, rdy: 1'b1,
    vld: 1'b0};

  qus_buf_st_t q;
  qus_buf_st_t d;

  // Flags are registered so that the top's ports come from flip-flops
  assign in_ready_o  = q.rdy;
  assign out_valid_o = q.vld;
  assign out_data_o  = q.mem[0];

  always_comb begin
    d = q;
    if (out_ready_i && q.vld) begin
      d.mem[0] = q.mem[1];
      d.cnt    = d.cnt - 2'h1;
    end
    // Pop first so that a push lands behind the word that stays
    if (in_valid_i && q.rdy) begin
      d.mem[d.cnt[0]] = in_data_i;
      d.cnt           = d.cnt + 2'h1;
    end
    d.rdy = (d.cnt != qus_pkg::BUF_DEPTH);
    d.vld = (d.cnt != 2'h0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= BUF_RST;
    end else begin
      q <= d;
    end
  end
endmodule

//--- qus_top_assertions.sv
// Checker of the quad serial pin block, bound to every qus_top.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ns
module qus_top_chk (
  input wire logic            REF_CLK_I,                 // clock
  input wire logic            RSTN_I,                    // reset
  input wire logic            FIFO_STATUS_SELECT_N_I,    // select
  input wire logic [7:0]      DATA_O,                    // snapshot
  input wire logic            DATA_OE_O,                 // drive
  input wire logic [3:0]      TX_READY_O,                // tx room
  input wire logic [3:0]      RX_VALID_O,                // rx held
  input wire logic [3:0]      TRANSMIT_READY_N_O,        // pin
  input wire logic [3:0]      RECEIVE_READY_N_O,         // pin
  input wire logic [3:0]      TX_O,                      // serial out
  input wire logic [3:0]      INFRARED_TX_O,             // ir out
  input wire logic [3:0]      INFRARED_SELECT_I,         // mode
  input wire logic [3:0]      DATA_TERMINAL_READY_BIT_I, // dtr bit
  input wire logic [3:0]      DTR_N_O,                   // dtr pin
  input wire logic [3:0]      CTS_N_I,                   // cts pin
  input wire logic [3:0]      CTS_STATUS_O               // cts seen
);
  default clocking dc @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  property p_oe_on;
    (!FIFO_STATUS_SELECT_N_I) [*3] |=> DATA_OE_O;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  property p_oe_off;
    FIFO_STATUS_SELECT_N_I [*3] |=> !DATA_OE_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus left driven");
  property p_snap;
    DATA_OE_O && $past(RSTN_I) |->
      DATA_O == {$past(RECEIVE_READY_N_O), ~$past(TRANSMIT_READY_N_O)};
  endproperty
  a_snap: assert property (p_snap) else $error("bad snapshot");
  property p_transmit_ready_n;
    $past(RSTN_I) |-> TRANSMIT_READY_N_O == ~$past(TX_READY_O);
  endproperty
  a_transmit_ready_n: assert property (p_transmit_ready_n) else $error("bad tx ready");
  property p_receive_ready_n;
    $past(RSTN_I) |-> RECEIVE_READY_N_O == ~$past(RX_VALID_O);
  endproperty
  a_receive_ready_n: assert property (p_receive_ready_n) else $error("bad rx ready");
  property p_ir;
    $past(RSTN_I) |-> ((TX_O ^ INFRARED_TX_O) & INFRARED_SELECT_I
      & $past(INFRARED_SELECT_I)) == 4'h0;
  endproperty
  a_ir: assert property (p_ir) else $error("ir mode mismatch");
  property p_ir_plain;
    $past(RSTN_I) |-> (TX_O & INFRARED_TX_O
      & ~$past(INFRARED_SELECT_I)) == 4'h0;
  endproperty
  a_ir_plain: assert property (p_ir_plain) else $error("ir pulse on 1");
  property p_dtr;
    $past(RSTN_I) |-> DTR_N_O == ~$past(DATA_TERMINAL_READY_BIT_I);
  endproperty
  a_dtr: assert property (p_dtr) else $error("bad dtr");
  property p_cts;
    $past(RSTN_I) && $past(RSTN_I, 2) |-> CTS_STATUS_O == ~$past(CTS_N_I, 2);
  endproperty
  a_cts: assert property (p_cts) else $error("bad cts status");
endmodule
bind qus_top qus_top_chk qus_top_chk_inst (.*);

//--- qus_partner.sv
// Remote station: a looped cable with crossed handshake lines.
// Assumes the bench drives stall_i to make the remote hold off.
`timescale 1ns/1ns
module qus_partner (
  input  wire logic [3:0] tx_i,    // station transmit
  input  wire logic [3:0] rts_n_i, // station rts
  input  wire logic [3:0] dtr_n_i, // station dtr
  input  wire logic [3:0] stall_i, // remote busy
  output logic      [3:0] rx_o,    // line back
  output logic      [3:0] cts_n_o, // clear to send
  output logic      [3:0] dsr_n_o, // set ready
  output logic      [3:0] cd_n_o   // carrier
);
  assign rx_o    = tx_i;
  assign cts_n_o = rts_n_i | stall_i;
  assign dsr_n_o = dtr_n_i;
  assign cd_n_o  = dtr_n_i | stall_i;
endmodule

//--- qus_top_bench.sv
// Self-checking bench: design looped through the remote station model.
// Assumes a small BAUD_DIV so that frames take 320 clocks.
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module qus_top_bench;
  logic            REF_CLK_I = 1'b0, RSTN_I = 1'b0;
  logic            FIFO_STATUS_SELECT_N_I = 1'b1, DATA_OE_O;
  logic [3:0][7:0] TX_DATA_I = '0, RX_DATA_O;
  logic [3:0]      TX_VALID_I = '0, RX_READY_I = '0, INFRARED_SELECT_I = '0;
  logic [3:0]      REQUEST_TO_SEND_BIT_I = '0, DATA_TERMINAL_READY_BIT_I = '0;
  logic [3:0]      AUTO_RTS_ENABLE_I = '0, AUTO_CTS_ENABLE_I = '0, stall = '0;
  logic [7:0]      DATA_O, exp_w;
  logic [3:0]      TX_READY_O, RX_VALID_O, TX_O, INFRARED_TX_O, RX_I, RTS_N_O;
  logic [3:0]      DTR_N_O, CTS_N_I, DSR_N_I, CD_N_I, CTS_STATUS_O;
  logic [3:0]      DSR_STATUS_O, CD_STATUS_O;
  logic [3:0]      TRANSMIT_READY_N_O, RECEIVE_READY_N_O;
  int              failures = 0, n_tests = 0, cyc = 0;
  logic [7:0]      q[4][$];

  qus_top #(.BAUD_DIV(16'h0002)) qus_top_inst (.*);
  qus_partner qus_partner_inst (.tx_i(TX_O), .rts_n_i(RTS_N_O),
    .dtr_n_i(DTR_N_O), .stall_i(stall), .rx_o(RX_I), .cts_n_o(CTS_N_I),
    .dsr_n_o(DSR_N_I), .cd_n_o(CD_N_I));

  always #5 REF_CLK_I = ~REF_CLK_I;

  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      summarize();
    end
  end

  // Every word handed to the host must be the oldest one sent
  always @(posedge REF_CLK_I)
    for (int c = 0; c < 4; c++)
      if (RSTN_I && RX_VALID_O[c] && RX_READY_I[c]) begin
        // Pop once: the check names its expected value twice
        exp_w = q[c].pop_front();
        `CHK(RX_DATA_O[c], exp_w)
      end

  task automatic tk(int n = 1);
    repeat (n) @(posedge REF_CLK_I);
    #1;
  endtask

  // Ready is a flop, so its settled level is what the next edge samples
  task automatic taken(int c);
    int k;
    k = 0;
    while (!TX_READY_O[c] && k < 3000) begin
      k++;
      tk();
    end
    tk();
  endtask

  // Valid stays up between words so they go back to back
  task automatic send(int c, int n);
    for (int i = 0; i < n; i++) begin
      TX_DATA_I[c] = 8'($urandom);
      TX_VALID_I[c] = 1'b1;
      q[c].push_back(TX_DATA_I[c]);
      taken(c);
    end
    TX_VALID_I[c] = 1'b0;
  endtask

  task automatic drain(logic [3:0] active);
    int k;
    logic [3:0] seen;
    k = 0;
    seen = 4'h0;
    while (q[0].size() + q[1].size() + q[2].size() + q[3].size() > 0
           && k < 4000) begin
      k++;
      tk();
      seen = seen | INFRARED_TX_O;
    end
    `CHK(q[0].size() + q[1].size() + q[2].size() + q[3].size(), 0)
    // Every frame has a zero start bit, so each busy channel pulses
    `CHK(seen, active)
  endtask

  task automatic snap(logic [7:0] e);
    FIFO_STATUS_SELECT_N_I = 1'b0;
    tk(3);
    `CHK(DATA_OE_O, 1'b1)
    `CHK(DATA_O, e)
    FIFO_STATUS_SELECT_N_I = 1'b1;
    tk(3);
    `CHK(DATA_OE_O, 1'b0)
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hec85));
    tk(16);
    `CHK(TX_O, 4'hf)
    `CHK(INFRARED_TX_O, 4'h0)
    RSTN_I = 1'b1;
    snap({4'hf, ~4'h0});
    $display("Test reset and snapshot done");
    for (int r = 0; r < 3; r++) begin
      INFRARED_SELECT_I = 4'($urandom);
      REQUEST_TO_SEND_BIT_I = 4'($urandom);
      DATA_TERMINAL_READY_BIT_I = 4'($urandom);
      stall = 4'($urandom);
      RX_READY_I = 4'hf;
      tk(40);
      `CHK(RTS_N_O, ~REQUEST_TO_SEND_BIT_I)
      `CHK(DTR_N_O, ~DATA_TERMINAL_READY_BIT_I)
      `CHK(CTS_STATUS_O, REQUEST_TO_SEND_BIT_I & ~stall)
      `CHK(DSR_STATUS_O, DATA_TERMINAL_READY_BIT_I)
      `CHK(CD_STATUS_O, DATA_TERMINAL_READY_BIT_I & ~stall)
      // Set-ready and carrier levels are random here and must not matter
      for (int c = 0; c < 4; c++)
        send(c, 2);
      drain(4'hf);
      `CHK(TX_O, ~INFRARED_SELECT_I)
      `CHK(INFRARED_TX_O, 4'h0)
    end
    $display("Test traffic done");
    INFRARED_SELECT_I = 4'h0;
    stall = 4'h0;
    RX_READY_I = 4'he;
    REQUEST_TO_SEND_BIT_I = 4'hf;
    tk(40);
    AUTO_RTS_ENABLE_I = 4'h1;
    AUTO_CTS_ENABLE_I = 4'h1;
    send(0, 4);
    tk();
    TX_DATA_I[0] = 8'($urandom);
    TX_VALID_I[0] = 1'b1;
    q[0].push_back(TX_DATA_I[0]);
    tk(800);
    `CHK(TX_READY_O[0], 1'b0)
    `CHK(RTS_N_O[0], 1'b1)
    snap({4'b1110, ~4'b0001});
    RX_READY_I[0] = 1'b1;
    taken(0);
    TX_VALID_I[0] = 1'b0;
    drain(4'h1);
    $display("Test flow control done");
    summarize();
  end
endmodule
